// ===== simdr_top.sv
// Two-wire master data-receive unit: two channels, APB register file, open-drain pins.
// Assumes an APB master on clk; pins are open drain with external pull-ups.
// Notes on behaviour
// - A byte is only received after the address field was sent (address-sent bit).
// - After the last byte software stops the channel and the bus is released.
// - Only a transfer-end interrupt per byte; buffer-empty mode has no effect.
// - Overrun is the only error flag this mode can raise.
// - Each received byte appears in the low 8 bits of the data register.
// - Data line is driven without inversion and idles high.
// - Bytes shift in MSB first, no parity, then one acknowledge bit period.
// - Output-level register: 11,9,3,1 read one; 10,8,2,0 carry live levels.
// - Start bits 2 and 0 start channels 2 and 0; other bits ignored.
// - Two independent channels, each with its own pins and interrupt.
// - Writing dummy FFH with receive enabled launches one byte, SDA released.
// - Last byte gets no acknowledge: output enable is cleared beforehand.
// - Reading the data register clears buffer-full.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module simdr_top
  import simdr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel 0 pins
  input wire logic clock_pin_a_in,
  output logic clock_pin_a_out,
  output logic clock_pin_a_oe,
  input wire logic data_pin_a_in,
  output logic data_pin_a_out,
  output logic data_pin_a_oe,
  // Channel 2 pins
  input wire logic clock_pin_b_in,
  output logic clock_pin_b_out,
  output logic clock_pin_b_oe,
  input wire logic data_pin_b_in,
  output logic data_pin_b_out,
  output logic data_pin_b_oe,
  // Transfer-end interrupts
  output logic transfer_end_irq_a,
  output logic transfer_end_irq_b
);
  // Bus decode
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire rd_en = access & ~pwrite;
  wire levels_hit = paddr == ADDR_LEVELS;
  wire out_en_hit = paddr == ADDR_OUT_EN;
  wire start_hit = paddr == ADDR_START;
  wire stop_hit = paddr == ADDR_STOP;
  wire enabled_hit = paddr == ADDR_ENABLED;
  wire common_hit = levels_hit | out_en_hit | start_hit | stop_hit | enabled_hit;

  // Per-channel views gathered for the shared registers and the pins
  wire [NCH-1:0] scl_in_w = {clock_pin_b_in, clock_pin_a_in};
  wire [NCH-1:0] sda_in_w = {data_pin_b_in, data_pin_a_in};
  wire [NCH-1:0] ch_hit;
  wire [NCH-1:0] se_w;
  wire [NCH-1:0] done_w;
  wire [NCH-1:0] clk_lvl_w;
  wire [NCH-1:0] dat_lvl_w;
  wire [15:0] ch_rd [NCH];

  // Output enable per channel; cleared by software before the last byte
  logic [NCH-1:0] out_en;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_en <= OUT_EN_RESET;
    end else if (wr_en && out_en_hit) begin
      out_en <= {pwdata[2], pwdata[0]};
    end
  end

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      localparam logic [11:0] BASE = ADDR_CH_STRIDE * 12'(i);
      localparam int START_BIT = 2 * i;

      simdr_chan_if lnk ();

      logic [15:0] mode;
      logic [15:0] oper;
      logic [6:0] div;
      logic [7:0] rx_data;
      logic bff;
      logic ovf;
      logic se;
      logic clk_lvl;
      logic dat_lvl;

      wire mode_hit = paddr == BASE + ADDR_MODE;
      wire oper_hit = paddr == BASE + ADDR_OPER;
      wire data_hit = paddr == BASE + ADDR_DATA;
      wire stat_hit = paddr == BASE + ADDR_STAT;
      wire busy = lnk.busy;
      wire rx_mode = oper[OPER_RXE_BIT] & ~oper[OPER_TXE_BIT];
      wire addr_sent = oper[OPER_ADDR_SENT_BIT];
      wire start_req = wr_en & start_hit & pwdata[START_BIT];
      wire stop_req = wr_en & stop_hit & pwdata[START_BIT];
      wire data_wr = wr_en & data_hit;
      wire data_rd = rd_en & data_hit;
      // Launch needs a started channel in receive mode past the address phase
      wire launch = data_wr & se & rx_mode & addr_sent & ~busy;
      wire ovf_clr = wr_en & stat_hit & pwdata[STAT_OVF_BIT];
      wire [15:0] oper_next = busy ?
        ((oper & ~OPER_RUN_MASK) | (pwdata[15:0] & OPER_RUN_MASK)) : pwdata[15:0];
      wire [15:0] stat_word = 16'(busy) << STAT_TSF_BIT | 16'(bff) << STAT_BFF_BIT
        | 16'(ovf) << STAT_OVF_BIT;

      assign lnk.launch = launch;
      assign lnk.div = div;
      assign lnk.scl_in = scl_in_w[i];
      assign lnk.sda_in = sda_in_w[i];

      simdr_chan simdr_chan_inst (
        .clk(clk),
        .rst(rst),
        .lnk(lnk)
      );

      // Mode bits are stored only; the receive path ignores buffer-empty mode
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mode <= MODE_RESET;
        end else if (wr_en && mode_hit && !busy) begin
          mode <= pwdata[15:0];
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          oper <= OPER_RESET;
        end else if (wr_en && oper_hit) begin
          oper <= oper_next;
        end
      end

      // Divider only moves while stopped, so the address-phase rate carries on
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          div <= DIV_RESET;
        end else if (data_wr && !se) begin
          div <= pwdata[DATA_DIV_MSB:DATA_DIV_LSB];
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          rx_data <= 8'h00;
        end else if (lnk.done) begin
          rx_data <= lnk.rx_byte;
        end
      end

      // Completion wins over a read or clear in the same cycle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          bff <= 1'b0;
        end else if (lnk.done) begin
          bff <= 1'b1;
        end else if (data_rd) begin
          bff <= 1'b0;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ovf <= 1'b0;
        end else if (lnk.done && bff) begin
          ovf <= 1'b1;
        end else if (ovf_clr) begin
          ovf <= 1'b0;
        end
      end

      // Stop wins: it ends the channel so software can shape the stop condition
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          se <= 1'b0;
        end else if (stop_req) begin
          se <= 1'b0;
        end else if (start_req) begin
          se <= 1'b1;
        end
      end

      // Engine owns the levels while it runs; software owns them otherwise
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          clk_lvl <= LEVELS_RESET[LEVELS_CLK_BASE + 2 * i];
          dat_lvl <= LEVELS_RESET[2 * i];
        end else if (busy) begin
          clk_lvl <= lnk.scl_level;
          // Without output enable SDA stays released, so the slave can send and a NACK results
          dat_lvl <= lnk.sda_level | ~out_en[i];
        end else if (wr_en && levels_hit) begin
          clk_lvl <= pwdata[LEVELS_CLK_BASE + 2 * i];
          dat_lvl <= pwdata[2 * i];
        end
      end

      assign ch_hit[i] = mode_hit | oper_hit | data_hit | stat_hit;
      assign se_w[i] = se;
      assign done_w[i] = lnk.done;
      assign clk_lvl_w[i] = clk_lvl;
      assign dat_lvl_w[i] = dat_lvl;
      assign ch_rd[i] = mode_hit ? mode :
                        oper_hit ? oper :
                        data_hit ? {div, 1'b0, rx_data} :
                        stat_hit ? stat_word : 16'h0000;
    end
  endgenerate

  // Shared read words
  wire [15:0] levels_word = LEVELS_FIXED
    | {5'h00, clk_lvl_w[1], 1'b0, clk_lvl_w[0], 8'h00}
    | {12'h000, 1'b0, dat_lvl_w[1], 1'b0, dat_lvl_w[0]};
  wire [15:0] out_en_word = {13'h0000, out_en[1], 1'b0, out_en[0]};
  wire [15:0] enabled_word = {13'h0000, se_w[1], 1'b0, se_w[0]};
  wire [15:0] common_rd = levels_hit ? levels_word :
                          out_en_hit ? out_en_word :
                          enabled_hit ? enabled_word : 16'h0000;
  wire mapped = (|ch_hit) | common_hit;

  // Zero-wait slave; unmapped addresses answer with an error and read zero
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = {16'h0000, ch_rd[0] | ch_rd[1] | common_rd};

  // Open drain: low level drives the pin, high level releases it
  assign clock_pin_a_out = 1'b0;
  assign clock_pin_a_oe = ~clk_lvl_w[0];
  assign data_pin_a_out = 1'b0;
  assign data_pin_a_oe = ~dat_lvl_w[0];
  assign clock_pin_b_out = 1'b0;
  assign clock_pin_b_oe = ~clk_lvl_w[1];
  assign data_pin_b_out = 1'b0;
  assign data_pin_b_oe = ~dat_lvl_w[1];

  assign transfer_end_irq_a = done_w[0];
  assign transfer_end_irq_b = done_w[1];
endmodule : simdr_top

// ===== simdr_pkg.sv
// Constants shared by the two-wire receive channels and their register file.
// Assumes a 32-bit APB slave port with 12-bit byte addresses.
package simdr_pkg;
  localparam int NCH = 2;
  localparam int PADDR_W = 12;

  // Per-channel block: channel index i sits at i * ADDR_CH_STRIDE
  localparam logic [11:0] ADDR_CH_STRIDE = 12'h010;
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_OPER = 12'h004;
  localparam logic [11:0] ADDR_DATA = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;
  // Shared registers
  localparam logic [11:0] ADDR_LEVELS = 12'h020;
  localparam logic [11:0] ADDR_OUT_EN = 12'h024;
  localparam logic [11:0] ADDR_START = 12'h028;
  localparam logic [11:0] ADDR_STOP = 12'h02c;
  localparam logic [11:0] ADDR_ENABLED = 12'h030;

  // Operation register fields
  localparam int OPER_TXE_BIT = 15;
  localparam int OPER_RXE_BIT = 14;
  localparam int OPER_ADDR_SENT_BIT = 0;
  localparam logic [15:0] OPER_RUN_MASK = 16'hc000;
  // Data register fields
  localparam int DATA_DIV_MSB = 15;
  localparam int DATA_DIV_LSB = 9;
  // Status register fields
  localparam int STAT_TSF_BIT = 6;
  localparam int STAT_BFF_BIT = 5;
  localparam int STAT_OVF_BIT = 0;
  // Output-level register: fixed ones, level bits per channel index
  localparam logic [15:0] LEVELS_FIXED = 16'h0a0a;
  localparam int LEVELS_CLK_BASE = 8;

  // Reset values
  localparam logic [15:0] MODE_RESET = 16'h0020;
  localparam logic [15:0] OPER_RESET = 16'h0000;
  localparam logic [6:0] DIV_RESET = 7'h01;
  localparam logic [15:0] LEVELS_RESET = 16'h0f0f;
  localparam logic [NCH-1:0] OUT_EN_RESET = 2'h0;

  // Bit periods: 8 data bits then the acknowledge period
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum {SIMDR_IDLE, SIMDR_LOW, SIMDR_HIGH} simdr_state_type;
endpackage : simdr_pkg

// ===== simdr_chan_if.sv
// Bundle between the register file and one receive engine.
// Both ends run on the same clk; pin inputs are raw and synchronised by the engine.
`timescale 1ns/1ps
interface simdr_chan_if;
  logic launch;
  logic [6:0] div;
  logic scl_in;
  logic sda_in;
  logic busy;
  logic done;
  logic [7:0] rx_byte;
  logic scl_level;
  logic sda_level;

  modport ctrl (
    output launch,
    output div,
    output scl_in,
    output sda_in,
    input busy,
    input done,
    input rx_byte,
    input scl_level,
    input sda_level
  );
  modport eng (
    input launch,
    input div,
    input scl_in,
    input sda_in,
    output busy,
    output done,
    output rx_byte,
    output scl_level,
    output sda_level
  );
endinterface : simdr_chan_if

// ===== simdr_chan.sv
// Bit engine of one receive channel: makes SCL, samples SDA, drives the acknowledge.
// Assumes the register file only launches it while idle.
`timescale 1ns/1ps
module simdr_chan
  import simdr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register side
  simdr_chan_if.eng lnk
);
  logic scl_meta;
  logic scl_s;
  logic sda_meta;
  logic sda_s;
  simdr_state_type state;
  logic [6:0] cnt;
  logic [3:0] bitn;
  logic [7:0] shift;
  logic scl_q;
  logic sda_q;
  logic done_q;

  wire half_over = cnt == 7'h00;
  // Slave may hold SCL low; the high half only counts once the line is seen high
  wire high_run = scl_s;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_meta <= lnk.scl_in;
      scl_s <= scl_meta;
      sda_meta <= lnk.sda_in;
      sda_s <= sda_meta;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SIMDR_IDLE;
      cnt <= 7'h00;
      bitn <= 4'h0;
      shift <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state)
        SIMDR_IDLE: begin
          if (lnk.launch) begin
            state <= SIMDR_LOW;
            cnt <= lnk.div;
            bitn <= 4'h0;
            scl_q <= 1'b0;
            sda_q <= 1'b1;
          end
        end
        SIMDR_LOW: begin
          if (half_over) begin
            state <= SIMDR_HIGH;
            cnt <= lnk.div;
            scl_q <= 1'b1;
          end else begin
            cnt <= cnt - 7'h01;
          end
        end
        SIMDR_HIGH: begin
          if (high_run && !half_over) begin
            cnt <= cnt - 7'h01;
          end else if (high_run) begin
            scl_q <= 1'b0;
            cnt <= lnk.div;
            if (bitn == ACK_BIT) begin
              state <= SIMDR_IDLE;
              done_q <= 1'b1;
            end else begin
              shift <= {shift[6:0], sda_s};
              bitn <= bitn + 4'h1;
              state <= SIMDR_LOW;
              // Pull SDA low for the acknowledge period, release it otherwise
              sda_q <= (bitn == LAST_DATA_BIT) ? 1'b0 : 1'b1;
            end
          end
        end
        default: begin
          state <= SIMDR_IDLE;
        end
      endcase
    end
  end

  assign lnk.busy = state != SIMDR_IDLE;
  assign lnk.done = done_q;
  assign lnk.rx_byte = shift;
  assign lnk.scl_level = scl_q;
  assign lnk.sda_level = sda_q;
endmodule : simdr_chan

// ===== simdr_checker.sv
// Port-level checker for the two-wire receive unit.
// Assumes it is bound to simdr_top and sees only its ports.
`timescale 1ns/1ps
module simdr_checker
  import simdr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pins and interrupts
  input wire logic clock_pin_a_out,
  input wire logic data_pin_a_out,
  input wire logic clock_pin_a_oe,
  input wire logic data_pin_a_oe,
  input wire logic clock_pin_b_oe,
  input wire logic data_pin_b_oe,
  input wire logic transfer_end_irq_a,
  input wire logic transfer_end_irq_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_lv = psel && !pwrite && paddr == ADDR_LEVELS;

  a_pins_open_drain: assert property (!clock_pin_a_out && !data_pin_a_out)
    else $error("pin driven high");
  a_irq_gap_a: assert property (transfer_end_irq_a |=> !transfer_end_irq_a [*8])
    else $error("irq a too close");
  a_irq_gap_b: assert property (transfer_end_irq_b |=> !transfer_end_irq_b [*8])
    else $error("irq b too close");
  a_scl_low_min: assert property ($rose(clock_pin_a_oe) |-> clock_pin_a_oe [*2])
    else $error("scl low half short");
  a_sda_scl_low: assert property ($rose(data_pin_a_oe) |-> clock_pin_a_oe)
    else $error("sda pulled while scl high");
  a_levels_fixed: assert property (rd_lv |-> (prdata & 32'hfffffafa) == {16'h0, LEVELS_FIXED})
    else $error("levels fixed bits wrong");
  a_levels_live: assert property (rd_lv |-> prdata[8] == !clock_pin_a_oe
    && prdata[0] == !data_pin_a_oe && prdata[10] == !clock_pin_b_oe && prdata[2] == !data_pin_b_oe)
    else $error("levels not live");
  a_unmapped_err: assert property (psel && penable && paddr == 12'h034 |-> pslverr)
    else $error("unmapped not refused");
  a_start_reads_zero: assert property (psel && !pwrite && paddr == ADDR_START |-> prdata == 0)
    else $error("start reads nonzero");
  a_data_upper: assert property (psel && !pwrite && paddr == ADDR_DATA |-> prdata[31:16] == 0
    && !prdata[8])
    else $error("data upper bits wrong");
  c_irq_a: cover property (transfer_end_irq_a);
  c_irq_b: cover property (transfer_end_irq_b);
  c_ack: cover property ($rose(data_pin_a_oe));
endmodule : simdr_checker

// ===== simdr_slave.sv
// Behavioural slave on one two-wire bus: sends bytes BASE + 35h*k, MSB first.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/1ps
module simdr_slave #(
  parameter logic [7:0] BASE = 8'h5a
) (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Slow answer: hold SCL low after each fall
  input wire logic stretch,
  // Pulls and seen acknowledge
  output logic scl_pull,
  output logic sda_pull,
  output logic ack_low
);
  logic [7:0] cur;
  int p;
  int k;
  logic idle;
  // Counting starts at the first real fall, so an unknown-to-high step at power-up is ignored
  logic armed;
  initial begin
    armed = 0;
    scl_pull = 0;
    sda_pull = 0;
    ack_low = 0;
    p = 0;
    k = 0;
    idle = 0;
    cur = BASE;
  end
  always @(negedge scl) begin
    armed = 1;
    if (idle || p == 8) begin
      sda_pull = 0;
    end else begin
      sda_pull = !cur[7 - p];
    end
    if (stretch) begin
      scl_pull = 1;
      #300;
      scl_pull = 0;
    end
  end
  always @(posedge scl) begin
    if (!armed) begin
      p = 0;
    end else if (!idle && p == 8) begin
      ack_low = !sda;
      idle = sda;
      k++;
      cur = BASE + 8'(8'h35 * k);
      p = 0;
    end else if (!idle) begin
      p++;
    end
  end
  // After a NACK the slave waits for the stop condition
  always @(posedge sda) begin
    if (scl) begin
      idle = 0;
    end
  end
endmodule : simdr_slave

// ===== simdr_bench.sv
// Self-checking bench for simdr_top with a slave model on each channel.
// Assumes 200 MHz clk; SCL half period set by divider 7 (about 80 ns link clock).
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module simdr_bench;
  import simdr_pkg::*;
  logic clk, rst, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [1:0] scl_oe, sda_oe, irq, sl_scl, sl_sda, ack_low;
  wire [1:0] scl_w = ~(scl_oe | sl_scl);
  wire [1:0] sda_w = ~(sda_oe | sl_sda);
  logic [1:0] stretch;
  int fails, comparisons, irq_cnt[2], stop_cnt, kk[2];
  simdr_top simdr_top_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clock_pin_a_in(scl_w[0]), .clock_pin_a_out(), .clock_pin_a_oe(scl_oe[0]),
    .data_pin_a_in(sda_w[0]), .data_pin_a_out(), .data_pin_a_oe(sda_oe[0]),
    .clock_pin_b_in(scl_w[1]), .clock_pin_b_out(), .clock_pin_b_oe(scl_oe[1]),
    .data_pin_b_in(sda_w[1]), .data_pin_b_out(), .data_pin_b_oe(sda_oe[1]),
    .transfer_end_irq_a(irq[0]), .transfer_end_irq_b(irq[1]));
  simdr_slave #(.BASE(8'h5a)) slave_a (.scl(scl_w[0]), .sda(sda_w[0]), .stretch(stretch[0]),
    .scl_pull(sl_scl[0]), .sda_pull(sl_sda[0]), .ack_low(ack_low[0]));
  simdr_slave #(.BASE(8'hc3)) slave_b (.scl(scl_w[1]), .sda(sda_w[1]), .stretch(stretch[1]),
    .scl_pull(sl_scl[1]), .sda_pull(sl_sda[1]), .ack_low(ack_low[1]));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irq[0] === 1'b1) irq_cnt[0]++;
    if (irq[1] === 1'b1) irq_cnt[1]++;
  end
  logic [1:0] ln_prev;
  // Stop seen on a clock edge: SDA rises while SCL was and stays high
  always @(posedge clk) begin
    if (sda_w[0] === 1'b1 && scl_w[0] === 1'b1 && ln_prev === 2'b10) stop_cnt++;
    ln_prev <= {scl_w[0], sda_w[0]};
  end
  task complete_run;
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb
  task rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CHK(n, e, rd)
  endtask : rdchk
  // Launch one byte and wait for its end-of-transfer pulse
  task rx_one(input int ch, input logic ack);
    int n;
    n = 0;
    apb(1, 12'(ch * 16) + ADDR_DATA, 32'h00ff);
    while (irq[ch] !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      complete_run;
    end
    repeat (3) @(posedge clk);
    `CHK("ack", ack, ack_low[ch])
    kk[ch]++;
  endtask : rx_one
  function automatic logic [31:0] exp_data(input int ch);
    return {16'h0, 7'h07, 1'b0, (ch ? 8'hc3 : 8'h5a) + 8'(8'h35 * (kk[ch] - 1))};
  endfunction : exp_data
  task t_setup;
    rdchk("mode", ADDR_MODE, {16'h0, MODE_RESET});
    rdchk("levels", ADDR_LEVELS, {16'h0, LEVELS_RESET});
    apb(0, 12'h034, 0);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
    apb(1, ADDR_DATA, 32'h0e00);
    apb(1, ADDR_CH_STRIDE + ADDR_DATA, 32'h0e00);
    apb(1, ADDR_START, 32'h000f);
    rdchk("started", ADDR_ENABLED, 32'h5);
    rdchk("divider", ADDR_DATA, 32'h0e00);
    apb(1, ADDR_OUT_EN, 32'h5);
  endtask : t_setup
  task t_gate;
    apb(1, ADDR_OPER, 32'h4000);
    apb(1, ADDR_DATA, 32'h00ff);
    apb(1, ADDR_OPER, 32'hc001);
    apb(1, ADDR_DATA, 32'h00ff);
    repeat (300) @(posedge clk);
    `CHK("gate irq", 0, irq_cnt[0])
    rdchk("gate stat", ADDR_STAT, 32'h0);
  endtask : t_gate
  task t_rx(input int ch);
    logic [11:0] b;
    b = 12'(ch * 16);
    apb(1, b + ADDR_OPER, 32'h4001);
    rx_one(ch, 1);
    rdchk("bff", b + ADDR_STAT, 32'h20);
    rdchk("data", b + ADDR_DATA, exp_data(ch));
    rdchk("bff clr", b + ADDR_STAT, 32'h0);
    rx_one(ch, 1);
    rx_one(ch, 1);
    rdchk("ovf", b + ADDR_STAT, 32'h21);
    rdchk("ovf data", b + ADDR_DATA, exp_data(ch));
    apb(1, b + ADDR_STAT, 32'h1);
    rdchk("ovf clr", b + ADDR_STAT, 32'h0);
    `CHK("irqs a", kk[0], irq_cnt[0])
    `CHK("irqs b", kk[1], irq_cnt[1])
  endtask : t_rx
  task t_busy;
    apb(1, ADDR_DATA, 32'h00ff);
    rdchk("busy", ADDR_STAT, 32'h40);
    apb(1, ADDR_MODE, 32'h1234);
    apb(1, ADDR_OPER, 32'h4000);
    rdchk("oper", ADDR_OPER, 32'h4001);
    repeat (400) @(posedge clk);
    kk[0]++;
    rdchk("mode kept", ADDR_MODE, {16'h0, MODE_RESET});
    rdchk("busy data", ADDR_DATA, exp_data(0));
  endtask : t_busy
  task t_last;
    apb(1, ADDR_OUT_EN, 32'h4);
    rx_one(0, 0);
    rdchk("last", ADDR_DATA, exp_data(0));
    apb(1, ADDR_STOP, 32'h1);
    apb(1, ADDR_LEVELS, 32'h0e0e);
    apb(1, ADDR_LEVELS, 32'h0f0e);
    apb(1, ADDR_LEVELS, 32'h0f0f);
    repeat (8) @(posedge clk);
    `CHK("stop", 1, stop_cnt)
    `CHK("idle", 2'h3, {scl_w[0], sda_w[0]})
    rdchk("levels end", ADDR_LEVELS, 32'h0f0f);
  endtask : t_last
  initial begin
    rst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    stretch = 2'h2;
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_setup;
    t_gate;
    t_rx(0);
    t_busy;
    t_rx(1);
    t_last;
    complete_run;
  end
  initial begin
    #300000;
    fails++;
    complete_run;
  end
endmodule : simdr_bench
bind simdr_top simdr_checker simdr_checker_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .clock_pin_a_out, .data_pin_a_out, .clock_pin_a_oe, .data_pin_a_oe,
  .clock_pin_b_oe, .data_pin_b_oe, .transfer_end_irq_a, .transfer_end_irq_b);
